// File: rtl/gcr_pkg.sv
// package for the global configuration register bank
// assumes a host front end on the same clock that turns i/o cycles into
// index and data strobes
package gcr_pkg;

  // ------------------------------------------------------------
  // register indices
  // ------------------------------------------------------------
  localparam logic [7:0] GLOBAL_LAST     = 8'h2f; // top of global range
  localparam logic [7:0] CTRL_IDX        = 8'h02; // global_control
  localparam logic [7:0] RSVD_FIRST      = 8'h03;
  localparam logic [7:0] RSVD_LAST       = 8'h06;
  localparam logic [7:0] FSEL_IDX        = 8'h07; // function_select

  // ------------------------------------------------------------
  // fields and reset values
  // ------------------------------------------------------------
  localparam int         CTRL_SOFT_BIT   = 0;
  localparam logic [7:0] CTRL_RESET      = 8'h00;
  localparam logic [7:0] FSEL_RESET      = 8'h00;
  localparam logic [7:0] INDEX_RESET     = 8'h00;
  localparam logic [7:0] READ_ZERO       = 8'h00;

  // ------------------------------------------------------------
  // host request carrier
  // ------------------------------------------------------------
  typedef struct packed {
    logic       idx_wr;  // write to the index port
    logic       dat_wr;  // write to the data port
    logic       dat_rd;  // read of the data port
    logic [7:0] wdata;   // byte written on either port
  } gcr_req_s;

endpackage

// File: rtl/gcr_bank.sv
// global configuration register bank behind the index and data ports
// assumes strobes arrive on clk from the host front end, one cycle each,
// and that setup mode entry and exit is decided outside this block
// the soft pulse leaves on soft_rst for the per-device registers
//
// Contract
// - decode global registers at indices 0x00-0x2f
// - all eight index bits select a register
// - unimplemented registers and bits ignore writes, read zero
// - index write first, data port then targets it
// - ports reach registers only in setup mode
// - control bit 0 written one triggers soft reset
// - soft reset bit clears itself in hardware
// - control register resets to zero on hard resets
// - indices 0x03-0x06 reserved: ignore writes, read zero
// - function select at 0x07 chooses current device
// - activation reaches only the selected device
// - function select clears on all resets and soft reset
module gcr_bank #(
  parameter int NUM_DEV = 16
) (
  // clock and reset (all power-on and hard resets combined)
  input  wire logic                  clk,
  input  wire logic                  rst,
  // host side
  input  wire logic                  cfg_mode,
  input  wire gcr_pkg::gcr_req_s     req,
  output logic [7:0]                 rd_data,
  output logic                       rd_valid,
  // chip side
  output logic                       soft_rst,
  output logic [7:0]                 fsel,
  output logic [NUM_DEV-1:0]         dev_wr_en,
  output logic [7:0]                 dev_idx,
  output logic [7:0]                 dev_wdata
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // exact eight-bit match, no upper bits dropped
  function automatic logic idx_is(input logic [7:0] a,
                                  input logic [7:0] b);
    return a == b;
  endfunction

  // inclusive index window on all eight bits, used for the reserved range decode
  function automatic logic idx_in(input logic [7:0] a,
                                  input logic [7:0] lo,
                                  input logic [7:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [7:0] index;
  logic [7:0] ctrl;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  // every select compares the full index byte, so an index such as 0x87
  // lands on the per-device side and never aliases onto 0x07
  wire logic in_global = index <= gcr_pkg::GLOBAL_LAST;
  wire logic sel_ctrl  = idx_is(index, gcr_pkg::CTRL_IDX);
  wire logic sel_fsel  = idx_is(index, gcr_pkg::FSEL_IDX);
  wire logic idx_take  = cfg_mode && req.idx_wr;
  wire logic dat_wr    = cfg_mode && req.dat_wr;
  wire logic dat_rd    = cfg_mode && req.dat_rd;
  wire logic soft_go   = dat_wr && sel_ctrl &&
                         req.wdata[gcr_pkg::CTRL_SOFT_BIT];
  wire logic fsel_wr   = dat_wr && sel_fsel;
  wire logic dev_wr    = dat_wr && !in_global;
  wire logic sel_rsvd  = idx_in(index, gcr_pkg::RSVD_FIRST,
                                gcr_pkg::RSVD_LAST);
  // device numbers past the forwarded width are dropped, not wrapped
  wire logic fsel_ok   = 32'(fsel) < NUM_DEV;
  // a data read is answered here only inside the global range
  wire logic rd_take   = dat_rd && in_global;

  // read mux: only function select reads back, the rest read zero
  wire logic [7:0] rd_mux = sel_fsel ? fsel
                                     : gcr_pkg::READ_ZERO;

  // read answer byte, forced to zero whenever no answer is due
  wire logic [7:0] next_rd_data = rd_take ? rd_mux
                                          : gcr_pkg::READ_ZERO;

  // next value of the control register: only bit 0 exists
  logic [7:0] next_ctrl;
  always_comb begin
    next_ctrl = gcr_pkg::CTRL_RESET;
    next_ctrl[gcr_pkg::CTRL_SOFT_BIT] = soft_go;
  end

  // per-device write enable, one-hot on the selected device
  // the select is taken in the write's own cycle, so a select change
  // that follows cannot move a write that is already under way
  logic [NUM_DEV-1:0] next_dev_wr_en;
  always_comb begin
    next_dev_wr_en = '0;
    if (dev_wr && fsel_ok) begin
      next_dev_wr_en[fsel[$clog2(NUM_DEV)-1:0]] = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // index register
  // ------------------------------------------------------------
  // the index survives data accesses and soft reset, so software may run
  // any number of data cycles after one index write
  always_ff @(posedge clk) begin
    if (rst) begin
      index <= gcr_pkg::INDEX_RESET;
    end else if (idx_take) begin
      index <= req.wdata;
    end
  end

  // ------------------------------------------------------------
  // global control: write-only, bit 0 self-clears after one cycle
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl <= gcr_pkg::CTRL_RESET;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // bits 7:1 of the control register are not built and stay zero; the
  // pulse itself is the soft reset that reaches the rest of the chip
  assign soft_rst = ctrl[gcr_pkg::CTRL_SOFT_BIT];

  // ------------------------------------------------------------
  // function select: soft reset wins over a same-cycle write
  // ------------------------------------------------------------
  // the soft pulse comes from the control flop one cycle after its write,
  // so a select write in that cycle is lost; software must wait a cycle
  // after a soft reset before choosing a device again
  always_ff @(posedge clk) begin
    if (rst || soft_rst) begin
      fsel <= gcr_pkg::FSEL_RESET;
    end else if (fsel_wr) begin
      fsel <= req.wdata;
    end
  end

  // ------------------------------------------------------------
  // read answer, one cycle after the data port read
  // ------------------------------------------------------------
  // both answer outputs come from flops, so the host side never sees
  // a decode glitch while the index or mode settles
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data  <= gcr_pkg::READ_ZERO;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_take;
      rd_data  <= next_rd_data;
    end
  end

  // ------------------------------------------------------------
  // forward per-device writes to the selected logical device
  // ------------------------------------------------------------
  // index and data travel with the enable, so a device sees one
  // coherent write in the cycle that its enable bit is high
  always_ff @(posedge clk) begin
    if (rst) begin
      dev_wr_en <= '0;
      dev_idx   <= gcr_pkg::INDEX_RESET;
      dev_wdata <= gcr_pkg::READ_ZERO;
    end else begin
      dev_wr_en <= next_dev_wr_en;
      dev_idx   <= index;
      dev_wdata <= req.wdata;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // the checks below watch only what this block drives; hard reset
  // disables them, and the hard reset check itself runs through reset

  a_index_capture: assert property (
    idx_take |=> index == $past(req.wdata))
    else $error("index port value not captured");

  a_index_no_alias: assert property (
    dat_wr && index[3:0] == gcr_pkg::FSEL_IDX[3:0] &&
    index[7:4] != 4'h0 && !soft_rst |=> $stable(fsel))
    else $error("aliased index changed function select");

  a_mode_gate: assert property (
    !cfg_mode && !soft_rst |=> $stable(fsel) && !rd_valid &&
    dev_wr_en == '0 && !soft_rst)
    else $error("access outside setup mode took effect");

  a_soft_cause: assert property (
    soft_rst == $past(soft_go))
    else $error("soft reset not tied to control write");

  a_soft_self_clear: assert property (
    soft_rst && !soft_go |=> !soft_rst)
    else $error("soft reset bit failed to clear");

  a_fsel_soft_clear: assert property (
    soft_rst |=> fsel == gcr_pkg::FSEL_RESET)
    else $error("soft reset left function select set");

  a_fsel_hold: assert property (
    fsel_wr && !soft_rst |=> fsel == $past(req.wdata) ##1
    ($past(fsel_wr) || $past(soft_rst) || $stable(fsel)))
    else $error("function select lost its value");

  a_read_zero: assert property (
    dat_rd && in_global && !sel_fsel |=> rd_valid &&
    rd_data == gcr_pkg::READ_ZERO)
    else $error("unimplemented register read nonzero");

  a_reserved_zero: assert property (
    dat_rd && index >= gcr_pkg::RSVD_FIRST &&
    index <= gcr_pkg::RSVD_LAST |=> rd_data == gcr_pkg::READ_ZERO)
    else $error("reserved register read nonzero");

  a_fsel_read: assert property (
    dat_rd && sel_fsel |=> rd_valid && rd_data == $past(fsel))
    else $error("function select read back wrong");

  a_global_only: assert property (
    dat_rd && !in_global |=> !rd_valid)
    else $error("read above global range answered here");

  a_dev_select: assert property (
    dev_wr_en != '0 |-> $onehot(dev_wr_en) &&
    dev_wr_en[$past(fsel[$clog2(NUM_DEV)-1:0])])
    else $error("device write reached unselected device");

  a_hard_reset: assert property (
    @(posedge clk) disable iff (1'b0)
    rst |=> !soft_rst && fsel == gcr_pkg::FSEL_RESET)
    else $error("hard reset values wrong");

  a_rd_idle_zero: assert property (
    !rd_valid |-> rd_data == gcr_pkg::READ_ZERO)
    else $error("read data not zero between answers");

  a_rd_cause: assert property (
    rd_valid |-> $past(dat_rd) && $past(in_global))
    else $error("read answer without a data port read");

  a_rd_needs_mode: assert property (
    rd_valid || soft_rst |-> $past(cfg_mode))
    else $error("answer or soft reset outside setup mode");

  a_index_hold: assert property (
    !idx_take |=> $stable(index))
    else $error("index changed without an index write");

  a_idx_refused: assert property (
    !cfg_mode |=> $stable(index))
    else $error("index taken outside setup mode");

  a_ctrl_bits_zero: assert property (
    ctrl[7:1] == 7'h00)
    else $error("unimplemented control bit set");

  a_ctrl_rd_zero: assert property (
    dat_rd && sel_ctrl |=> rd_valid && rd_data == gcr_pkg::READ_ZERO)
    else $error("write-only control read nonzero");

  a_soft_from_ctrl: assert property (
    soft_rst |-> $past(dat_wr) && $past(sel_ctrl))
    else $error("soft reset without a control write");

  a_fsel_no_stray: assert property (
    !fsel_wr && !soft_rst |=> $stable(fsel))
    else $error("function select changed with no write");

  a_dev_fields: assert property (
    dev_wr_en != '0 |-> dev_idx == $past(index) &&
    dev_wdata == $past(req.wdata) && $past(fsel_ok))
    else $error("device write carried wrong index or data");

  a_dev_outside: assert property (
    dev_wr_en != '0 |-> dev_idx > gcr_pkg::GLOBAL_LAST)
    else $error("global range write forwarded to a device");

  a_dev_needs_mode: assert property (
    dev_wr_en != '0 |-> $past(cfg_mode))
    else $error("device write outside setup mode");

  a_rsvd_no_effect: assert property (
    dat_wr && sel_rsvd && !soft_rst |=> $stable(fsel) &&
    dev_wr_en == '0 && !soft_rst)
    else $error("reserved register write took effect");

  // main scenarios: soft reset, select write, device write, refusals
  c_soft_reset: cover property (soft_go ##1 soft_rst);
  c_fsel_write: cover property (fsel_wr ##1 dat_rd && sel_fsel);
  c_dev_write:  cover property (dev_wr_en != '0);
  c_rsvd_read:  cover property (dat_rd && in_global && !sel_fsel);
  c_mode_refused: cover property (!cfg_mode && req.dat_wr);

endmodule

// File: testbench/gcr_host_model.sv
// host model: turns bench commands into one-cycle index and data strobes
// assumes commands come just after a rising edge of clk
module gcr_host_model (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // command from the bench: 0 index write, 1 data write, 2 data read
  input  wire logic              cmd_valid,
  input  wire logic [1:0]        cmd_kind,
  input  wire logic [7:0]        cmd_byte,
  // strobes to the bank
  output gcr_pkg::gcr_req_s      req
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // strobe generation
  // ----------------------------------------
  // idle byte is the inverse of the last one, so stale data never matches
  always_ff @(posedge clk) begin
    if (rst) req <= '0;
    else if (cmd_valid) req <= {cmd_kind == 2'd0, cmd_kind == 2'd1,
                                cmd_kind == 2'd2, cmd_byte};
    else req <= {3'b000, ~req.wdata};
  end
endmodule

// File: testbench/global_config_register_bank_tb_top.sv
// testbench top for the global configuration register bank
// assumes the host model above and the bank's package
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin \
  n_errors++; $display("[ERR] %s exp %h got %h", nm, ex, gt); end end
module global_config_register_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, cfg_mode, cmd_valid, rd_valid, soft_rst;
  logic [1:0] cmd_kind;
  logic [7:0] cmd_byte, rd_data, fsel, dev_idx, dev_wdata, v, s;
  logic [15:0] dev_wr_en;
  logic [31:0] seed, e;
  gcr_pkg::gcr_req_s req;
  int n_errors, total_checks, n_soft;
  logic [7:0] rq[$];
  logic [31:0] dq[$];
  logic [7:0] ign[9] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08,
                         8'h1f, 8'h2f};
  // ----------------------------------------
  // instances, clock, watchdog
  // ----------------------------------------
  gcr_host_model u_gcr_host_model (.clk(clk), .rst(rst),
    .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_byte(cmd_byte),
    .req(req));
  gcr_bank #(.NUM_DEV(16)) u_gcr_bank (.clk(clk), .rst(rst),
    .cfg_mode(cfg_mode), .req(req), .rd_data(rd_data), .rd_valid(rd_valid),
    .soft_rst(soft_rst), .fsel(fsel), .dev_wr_en(dev_wr_en),
    .dev_idx(dev_idx), .dev_wdata(dev_wdata));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #(8 * 5000);
    n_errors++;
    stop_test();
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task op(input logic [1:0] k, input logic [7:0] b);
    @(posedge clk); #1;
    cmd_valid = 1'b1; cmd_kind = k; cmd_byte = b;
  endtask
  task idle(input int n);
    repeat (n) begin @(posedge clk); #1; cmd_valid = 1'b0; end
  endtask
  task rd(input logic [7:0] i, input logic [7:0] x);
    op(2'd0, i); op(2'd2, 8'h00); rq.push_back(x);
  endtask
  task wr(input logic [7:0] i, input logic [7:0] d);
    op(2'd0, i); op(2'd1, d);
  endtask
  task stop_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ----------------------------------------
  // monitor: answers are matched to the oldest note
  // ----------------------------------------
  always @(negedge clk) if (rst === 1'b0) begin
    if (soft_rst === 1'b1) n_soft++;
    if (rd_valid === 1'b1) begin
      if (rq.size() == 0) `CHK("spurious read", 1'b0, 1'b1)
      else begin
        e[7:0] = rq.pop_front();
        `CHK("rd_data", e[7:0], rd_data)
      end
    end
    if (dev_wr_en !== 16'h0000) begin
      e = (dq.size() != 0) ? dq.pop_front() : 32'h0;
      `CHK("dev write", e, {dev_wr_en, dev_idx, dev_wdata})
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1; cfg_mode = 1'b1; cmd_valid = 1'b0; cmd_kind = 2'd0;
    cmd_byte = 8'h00; seed = 32'd7569;
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    rd(8'h07, 8'h00);
    rd(8'h02, 8'h00);
    v = 8'(xs()); wr(8'h07, v); idle(3);
    `CHK("fsel", v, fsel)
    rd(8'h07, v);
    foreach (ign[i]) begin wr(ign[i], 8'hff); rd(ign[i], 8'h00); end
    wr(8'h02, 8'hfe); rd(8'h02, 8'h00); idle(3);
    `CHK("fsel kept", v, fsel)
    s = {4'h0, 4'(xs() >> 28)}; wr(8'h07, s); v = 8'(xs());
    dq.push_back({16'h0001 << s, 8'h30, v}); wr(8'h30, v);
    dq.push_back({16'h0001 << s, 8'h87, 8'h5a}); wr(8'h87, 8'h5a);
    op(2'd2, 8'h00); idle(3);
    `CHK("fsel alias", s, fsel)
    op(2'd0, 8'h07); idle(2);
    cfg_mode = 1'b0; wr(8'h02, 8'haa); op(2'd2, 8'h00); idle(3);
    cfg_mode = 1'b1; op(2'd2, 8'h00); rq.push_back(s); idle(3);
    `CHK("fsel locked", s, fsel)
    wr(8'h02, 8'h01); idle(4);
    `CHK("soft pulses", 1, n_soft)
    `CHK("fsel soft", 8'h00, fsel)
    wr(8'h07, 8'h20); wr(8'h31, 8'h11); idle(3);
    rd(8'h02, 8'h00); wr(8'h07, 8'h3c); idle(2);
    `CHK("fsel pre", 8'h3c, fsel)
    rst = 1'b1; idle(2); rst = 1'b0;
    rd(8'h07, 8'h00); idle(4);
    `CHK("notes left", 0, rq.size() + dq.size())
    stop_test();
  end
endmodule
